// File: hdl/dsrp_sync.sv
`timescale 1ns/1ps
module dsrp_sync
  import dsrp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// File: hdl/dsrp_top.sv
`timescale 1ns/1ps
module dsrp_top
  import dsrp_pkg::*;
#(
  parameter int RESIDENCY_CYC = SR_MIN_RESIDENCY_CYC,
  parameter int REF_PERIOD_CYC = INTERNAL_REF_CYC
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic [9:0] ca_i,
  output logic self_refresh_o,
  output logic receivers_on_o,
  output logic exit_busy_o,
  output logic refresh_pulse_o,
  output logic [7:0] refresh_bank_o,
  output logic [7:0] refresh_seg_o,
  output logic [7:0] bank_mask_o,
  output logic [7:0] seg_mask_o
);
  initial
  begin
    if (REF_PERIOD_CYC < 1 || RESIDENCY_CYC <= REF_PERIOD_CYC)
      $error("dsrp_top: internal refresh must fall inside residency");
  end

  // ==========================================================
  // pin synchronisers and link clock edge detect
  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  logic [9:0] ca_s;
  logic ck_d;
  logic cke_prev;
  logic ck_rise;

  dsrp_sync #(.WIDTH(13)) u_sync
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({ck_i, cke_i, cs_n_i, ca_i}),
    .q_o({ck_s, cke_s, cs_n_s, ca_s})
  );

  assign ck_rise = ck_s & ~ck_d;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ck_d <= 1'b0;
    else
      ck_d <= ck_s;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cke_prev <= 1'b0;
    else if (ck_rise)
      cke_prev <= cke_s;
  end

  // ==========================================================
  // command decode on link rising edges
  logic sr_entry_cmd;
  logic mrw_rise;
  logic mrw_pend;
  logic [7:0] mrw_addr;

  // entry needs cke high on the previous edge
  assign sr_entry_cmd = ck_rise & ~cke_s & cke_prev & ~cs_n_s & ~ca_s[0] & ~ca_s[1] & ca_s[2];
  assign mrw_rise = ck_rise & cke_s & cke_prev & ~cs_n_s & ~ca_s[0] & ~ca_s[1] & ~ca_s[2] & ~ca_s[3];

  // mrw is two-edge: rise edge gives address high bits, fall edge low bits and data
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mrw_pend <= 1'b0;
      mrw_addr <= 8'h00;
    end
    else if (mrw_rise)
    begin
      mrw_pend <= 1'b1;
      mrw_addr <= {ca_s[9:4], 2'b00};
    end
    else if (ck_d & ~ck_s)
      mrw_pend <= 1'b0;
  end

  // ==========================================================
  // mask registers
  logic mrw_fall;
  logic [7:0] mrw_sel;
  dsrp_state_type state;

  assign mrw_fall = mrw_pend & ck_d & ~ck_s;
  assign mrw_sel = {mrw_addr[7:2], ca_s[1:0]};

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      bank_mask_o <= MASK_RESET;
      seg_mask_o <= MASK_RESET;
    end
    else if (mrw_fall && state == DSRP_ACTIVE)
    begin
      if (mrw_sel == BANK_MASK_ADDR)
        bank_mask_o <= ca_s[9:2];
      else if (mrw_sel == SEG_MASK_ADDR)
        seg_mask_o <= ca_s[9:2];
      // reserved address falls through with no effect
    end
  end

  // ==========================================================
  // self refresh state machine
  int unsigned cnt;
  int unsigned res_cnt;
  int unsigned ref_cnt;
  logic ref_done;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state <= DSRP_ACTIVE;
      cnt <= 0;
    end
    else
    begin
      unique case (state)
        DSRP_ACTIVE:
          if (sr_entry_cmd)
          begin
            state <= DSRP_SR_ENTRY;
            cnt <= 0;
          end
        DSRP_SR_ENTRY:
          // receivers stay on for the propagation delay, then go off
          if (ck_rise)
          begin
            if (cnt == PROP_DELAY_EDGES - 1)
              state <= DSRP_SR;
            cnt <= cnt + 1;
          end
        DSRP_SR:
          // exit needs cke high on a link rising edge; the link clock may be stopped here
          if (cke_s && ck_rise)
          begin
            state <= DSRP_SR_EXIT;
            cnt <= 0;
          end
        DSRP_SR_EXIT:
          // the registering edge starts the interval
          if (ck_rise)
          begin
            if (cnt == EXIT_INTERVAL_EDGES - 1)
              state <= DSRP_ACTIVE;
            cnt <= cnt + 1;
          end
      endcase
    end
  end

  // ==========================================================
  // internal refresh timer, free of the link clock
  logic in_sr;
  assign in_sr = (state == DSRP_SR_ENTRY) || (state == DSRP_SR);

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !in_sr)
    begin
      ref_cnt <= 0;
      res_cnt <= 0;
      ref_done <= 1'b0;
      refresh_pulse_o <= 1'b0;
    end
    else
    begin
      if (res_cnt < RESIDENCY_CYC)
        res_cnt <= res_cnt + 1;
      refresh_pulse_o <= 1'b0;
      if (ref_cnt == REF_PERIOD_CYC - 1)
      begin
        ref_cnt <= 0;
        refresh_pulse_o <= 1'b1;
        ref_done <= 1'b1;
      end
      else
        ref_cnt <= ref_cnt + 1;
    end
  end

  // masked banks and segments get no refresh; 1 means masked
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      refresh_bank_o <= 8'h00;
      refresh_seg_o <= 8'h00;
    end
    else
    begin
      refresh_bank_o <= in_sr ? ~bank_mask_o : 8'h00;
      refresh_seg_o <= (in_sr && bank_mask_o != 8'hff) ? ~seg_mask_o : 8'h00;
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      self_refresh_o <= 1'b0;
      receivers_on_o <= 1'b1;
      exit_busy_o <= 1'b0;
    end
    else
    begin
      self_refresh_o <= in_sr;
      receivers_on_o <= (state != DSRP_SR);
      exit_busy_o <= (state == DSRP_SR_EXIT);
    end
  end

  // ==========================================================
  // assertions
  a_entry_decode: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == DSRP_ACTIVE && sr_entry_cmd) |=> state == DSRP_SR_ENTRY)
    else $error("entry command not taken");
  a_refresh_in_res: assert property (@(posedge clk_i) disable iff (srst_i)
    (in_sr && res_cnt == RESIDENCY_CYC - 1) |-> ref_done)
    else $error("no internal refresh within residency");
  a_masks_frozen_sr: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == DSRP_SR && $past(state) == DSRP_SR) |-> $stable(bank_mask_o) && $stable(seg_mask_o))
    else $error("mask changed during self refresh");
  a_bank_mask_map: assert property (@(posedge clk_i) disable iff (srst_i)
    in_sr |=> refresh_bank_o == ~$past(bank_mask_o))
    else $error("bank refresh enables wrong");
  a_seg_mask_map: assert property (@(posedge clk_i) disable iff (srst_i)
    (in_sr && bank_mask_o != 8'hff) |=> refresh_seg_o == ~$past(seg_mask_o))
    else $error("segment refresh enables wrong");
  a_rsvd_no_effect: assert property (@(posedge clk_i) disable iff (srst_i)
    (mrw_fall && mrw_sel == RSVD_MASK_ADDR) |=> $stable(bank_mask_o) && $stable(seg_mask_o))
    else $error("reserved write changed a mask");
  a_mrw_bank_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (mrw_fall && state == DSRP_ACTIVE && mrw_sel == BANK_MASK_ADDR) |=> bank_mask_o == $past(ca_s[9:2]))
    else $error("bank mask write lost");
  a_rx_off_in_sr: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == DSRP_SR) |=> !receivers_on_o)
    else $error("receivers on in self refresh");
  a_exit_from_sr: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == DSRP_SR && cke_s && ck_rise) |=> state == DSRP_SR_EXIT ##1 exit_busy_o)
    else $error("exit not started");
endmodule

// File: include/dsrp_pkg.sv
package dsrp_pkg;
  localparam logic [7:0] BANK_MASK_ADDR = 8'h10;
  localparam logic [7:0] SEG_MASK_ADDR = 8'h11;
  localparam logic [7:0] RSVD_MASK_ADDR = 8'h12;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SR_MIN_RESIDENCY_NS = 15000;
  localparam int SR_MIN_RESIDENCY_CYC = (SR_MIN_RESIDENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTERNAL_REF_NS = 7800;
  localparam int INTERNAL_REF_CYC = INTERNAL_REF_NS / CLK_PERIOD_NS;
  localparam int PROP_DELAY_EDGES = 2;
  localparam int EXIT_INTERVAL_EDGES = 32;
  localparam int SEGMENTS = 8;
  localparam int BANKS = 8;
  typedef enum logic [1:0] {
    DSRP_ACTIVE = 2'b00,
    DSRP_SR_ENTRY = 2'b01,
    DSRP_SR = 2'b10,
    DSRP_SR_EXIT = 2'b11
  } dsrp_state_type;
endpackage

// File: verification/dsrp_ctrl_model.sv
`timescale 1ns/1ps
// ==========
// memory controller model
module dsrp_ctrl_model
(
  output logic ck_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic [9:0] ca_o
);
  initial
  begin
    ck_o = 1'b0;
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    ca_o = 10'h000;
  end
  // one link period, offset from the system clock edges
  task automatic cyc(input logic k, input logic c, input logic [9:0] r, input logic [9:0] f);
    #3 cke_o = k;
    cs_n_o = c;
    ca_o = r;
    #50 ck_o = 1'b1;
    #50 ca_o = f;
    #50 ck_o = 1'b0;
    #47;
  endtask
  // deselected cycles: ca is don't care, so it toggles
  task automatic nop(input int n);
    repeat (n) cyc(cke_o, 1'b1, ~ca_o, ~ca_o);
  endtask
  task automatic mode_register_write(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, {a[7:2], 4'h0}, {d, a[1:0]});
    nop(2);
  endtask
  task automatic self_refresh(input int stop_ns);
    nop(1);
    cyc(1'b0, 1'b0, 10'h004, 10'h004);
    nop(2);
    // clock halted, released pins toggle
    repeat (stop_ns / 10) #10 {cs_n_o, ca_o} = ~{cs_n_o, ca_o};
    nop(3);
    cyc(1'b1, 1'b1, ~ca_o, ~ca_o);
    nop(33);
    cyc(1'b1, 1'b0, 10'h00c, 10'h00c);
    nop(2);
  endtask
endmodule

// File: verification/dsrp_top_tb_top.sv
`timescale 1ns/1ps
// ==========
// self refresh and masking bench
module dsrp_top_tb_top
  import dsrp_pkg::*;
;
  localparam int RES = 40;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ck, cke, cs_n, sr, sr_q, rx, xb, rp;
  logic [9:0] ca;
  logic [7:0] rb, rs, bm, sm;
  int errors = 0;
  int n_compared = 0;
  int seed = 32'h0000_9737;
  int exp_bm = 0;
  int exp_sm = 0;
  int pulses = 0;
  int wait_cyc = 0;
  int busy_ck = 0;
  initial
    forever #12.5 clk_i = ~clk_i;
  initial
  begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
  end
  dsrp_ctrl_model u_ctrl (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
  dsrp_top #(.RESIDENCY_CYC(RES), .REF_PERIOD_CYC(10)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca),
    .self_refresh_o(sr), .receivers_on_o(rx), .exit_busy_o(xb), .refresh_pulse_o(rp),
    .refresh_bank_o(rb), .refresh_seg_o(rs), .bank_mask_o(bm), .seg_mask_o(sm));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ck)
    if (xb === 1'b1)
      busy_ck++;
  // sample away from the launching edge so outputs are settled
  always @(negedge clk_i)
  begin
    sr_q <= sr;
    if (sr === 1'b1 && sr_q === 1'b0)
      check(rx, 8'h01);
    if (sr === 1'b1 && pulses == 0)
      wait_cyc++;
    if (rp === 1'b1 && sr === 1'b1)
    begin
      pulses++;
      if (pulses > 2)
        check(rx, 8'h00);
      check(rb, 8'(~exp_bm));
      check(rs, 8'(exp_bm) == 8'hff ? 8'h00 : 8'(~exp_sm));
    end
  end
  initial
  begin
    #200us;
    errors++;
    give_verdict;
  end
  initial
  begin
    logic [7:0] d;
    repeat (6) @(posedge clk_i);
    #1;
    check(bm, 8'h00);
    check(sm, 8'h00);
    // one link edge with cke high so the first command sees cke high before it
    u_ctrl.nop(1);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      u_ctrl.mode_register_write(8'h10 + 8'(i), d);
      if (i == 0)
        exp_bm = d;
      if (i == 1)
        exp_sm = d;
      check(bm, 8'(exp_bm));
      check(sm, 8'(exp_sm));
    end
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 8'h82 : (k == 1) ? 8'hff : 8'($random(seed));
      u_ctrl.mode_register_write(BANK_MASK_ADDR, d);
      exp_bm = d;
      d = (k == 0) ? 8'h84 : 8'($random(seed));
      u_ctrl.mode_register_write(SEG_MASK_ADDR, d);
      exp_sm = d;
      pulses = 0;
      wait_cyc = 0;
      busy_ck = 0;
      u_ctrl.self_refresh(2000);
      check(8'(pulses != 0), 8'h01);
      check(8'(wait_cyc <= RES), 8'h01);
      check(8'(busy_ck >= 31 && busy_ck <= 33), 8'h01);
      check({xb, rx, sr}, 8'h02);
      check(bm, 8'(exp_bm));
      check(sm, 8'(exp_sm));
    end
    give_verdict;
  end
endmodule
